// >>> sfp_consts.svh
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define SFP_OP_BWR1 8'h84
`define SFP_OP_BWR2 8'h87
`define SFP_OP_PE1 8'h83
`define SFP_OP_PE2 8'h86
`define SFP_OP_PN1 8'h88
`define SFP_OP_PN2 8'h89
`define SFP_OP_MP1 8'h82
`define SFP_OP_MP2 8'h85
`define SFP_OP_RW1 8'h58
`define SFP_OP_RW2 8'h59
`define SFP_OP_XF1 8'h53
`define SFP_OP_XF2 8'h55
`define SFP_OP_CP1 8'h60
`define SFP_OP_CP2 8'h61
`define SFP_OP_STAT 8'h57
`define SFP_OPC_LAST 6'h07
`define SFP_ADR_LAST 6'h1F
`define SFP_CMD_FULL 6'h20
`define SFP_POS_LSB 0
`define SFP_POS_MSB 8
`define SFP_PG_LSB 9
`define SFP_PG_MSB 20
`define SFP_STAT_TOP 3'h7
`define SFP_RSV_BITS 3'h0
`define SFP_T_EP_MS 20
`define SFP_T_P_MS 14
`define SFP_T_XFR_US 150
`define SFP_CLK_MHZ 100
`define SFP_US_PER_MS 1000
`endif

// >>> sfp_pkg.sv
package sfp_pkg;
  typedef enum logic [2:0]
  {
    ENG_IDLE = 3'h0,
    ENG_FILL = 3'h1,
    ENG_CMP  = 3'h2,
    ENG_PROG = 3'h3,
    ENG_WAIT = 3'h4
  } sfp_eng_e;
  typedef enum logic [2:0]
  {
    OPK_XFR = 3'h0,
    OPK_CMP = 3'h1,
    OPK_PE  = 3'h2,
    OPK_PN  = 3'h3,
    OPK_RW  = 3'h4
  } sfp_opk_e;
  typedef logic [7:0] sfp_byte_t;
endpackage : sfp_pkg

// >>> sfp_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sfp_timer #(
  parameter int TW = 24
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  input  wire logic          i_start,
  input  wire logic [TW-1:0] i_load,
  output logic               o_zero
);
  import sfp_pkg::*;
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] cnt_nxt;

  generate
    if (TW < 2)
    begin : g_chk
      $error("Timer width too small.");
    end
  endgenerate

  // ==========================================================
  // Down counter.
  assign cnt_nxt = i_start ? i_load : ((cnt_r != '0) ? cnt_r - 1'b1 : cnt_r);
  assign o_zero  = (cnt_r == '0);

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end
endmodule : sfp_timer
`default_nettype wire

// >>> sfp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfp_consts.svh"
module sfp_core #(
  parameter int          PAGE_CNT   = 4096,
  parameter int          PAGE_BYTES = 264,
  parameter int          TW         = 24,
  parameter int unsigned EP_CYC     = `SFP_T_EP_MS * `SFP_US_PER_MS * `SFP_CLK_MHZ,
  parameter int unsigned P_CYC      = `SFP_T_P_MS * `SFP_US_PER_MS * `SFP_CLK_MHZ,
  parameter int unsigned XFR_CYC    = `SFP_T_XFR_US * `SFP_CLK_MHZ,
  // Density code value is arbitrary.
  parameter logic [2:0]  DENSITY    = 3'h5
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst,
  input  wire logic          i_cs_n,
  input  wire logic          i_sck,
  input  wire logic          i_si,
  output logic               o_so,
  output logic               o_so_oe,
  output logic               o_rdy_busy,
  output logic               o_rdy_busy_oe,
  output sfp_pkg::sfp_byte_t o_status
);
  import sfp_pkg::*;

  localparam int PW  = $clog2(PAGE_CNT);
  localparam int AW  = $clog2(PAGE_CNT * PAGE_BYTES);
  localparam int BW  = $clog2(2 * PAGE_BYTES);

  generate
    if ((PW < 1) || (PW > 12) || (PAGE_CNT != (1 << PW)))
    begin : g_chk_pg
      $error("Page count must be a power of two up to 4096.");
    end
    if ((PAGE_BYTES < 2) || (PAGE_BYTES > 512))
    begin : g_chk_pb
      $error("Page size must fit the nine-bit position.");
    end
    if ((XFR_CYC <= 2 * PAGE_BYTES) || (P_CYC <= 2 * PAGE_BYTES)
        || (EP_CYC <= 2 * PAGE_BYTES) || (EP_CYC >= (64'h1 << TW))
        || (P_CYC >= (64'h1 << TW)) || (XFR_CYC >= (64'h1 << TW)))
    begin : g_chk_t
      $error("Timer limits do not fit the copy time or the timer width.");
    end
  endgenerate

  localparam logic [8:0]    POS_LAST = 9'(PAGE_BYTES - 1);
  localparam logic [BW-1:0] BUF2_OFS = BW'(PAGE_BYTES);
  localparam logic [TW-1:0] LD_EP    = TW'(EP_CYC);
  localparam logic [TW-1:0] LD_P     = TW'(P_CYC);
  localparam logic [TW-1:0] LD_XFR   = TW'(XFR_CYC);

  // ==========================================================
  // Storage.
  sfp_byte_t buf_mem  [2 * PAGE_BYTES];
  sfp_byte_t page_mem [PAGE_CNT * PAGE_BYTES];

  // ==========================================================
  // Pin edge detection.
  logic       sck_q_r;
  logic       cs_q_r;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       sel_on;

  assign sel_on   = ~i_cs_n;
  assign sck_rise = sel_on & i_sck & ~sck_q_r;
  assign sck_fall = sel_on & ~i_sck & sck_q_r;
  assign cs_rise  = i_cs_n & ~cs_q_r;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      sck_q_r <= 1'b0;
      cs_q_r  <= 1'b1;
    end
    else
    begin
      sck_q_r <= i_sck;
      cs_q_r  <= i_cs_n;
    end
  end

  // ==========================================================
  // Command shifter.
  logic [5:0]  bit_cnt_r;
  logic [5:0]  bit_cnt_nxt;
  logic [7:0]  sr_r;
  logic [7:0]  sr_in;
  logic [7:0]  op_r;
  logic [23:0] adr_r;
  logic [23:0] adr_in;
  logic [2:0]  dbit_r;
  logic [8:0]  pos_r;
  logic [8:0]  pos_nxt;
  logic        opc_done;
  logic        adr_done;
  logic        cmd_full;
  logic        data_bit;
  logic        byte_done;

  assign sr_in     = {sr_r[6:0], i_si};
  assign adr_in    = {adr_r[22:0], i_si};
  assign cmd_full  = (bit_cnt_r == `SFP_CMD_FULL);
  assign opc_done  = sck_rise & (bit_cnt_r == `SFP_OPC_LAST);
  assign adr_done  = sck_rise & (bit_cnt_r == `SFP_ADR_LAST);
  assign data_bit  = sck_rise & cmd_full;
  assign byte_done = data_bit & (dbit_r == 3'h7);
  assign pos_nxt   = (pos_r == POS_LAST) ? 9'h000 : pos_r + 9'h001;
  assign bit_cnt_nxt = (sck_rise & ~cmd_full) ? bit_cnt_r + 6'h01 : bit_cnt_r;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      bit_cnt_r <= 6'h00;
      sr_r      <= 8'h00;
      op_r      <= 8'h00;
      adr_r     <= 24'h000000;
      dbit_r    <= 3'h0;
      pos_r     <= 9'h000;
    end
    else if (i_cs_n)
    begin
      bit_cnt_r <= 6'h00;
      dbit_r    <= 3'h0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_nxt;
      if (sck_rise)
        sr_r <= sr_in;
      if (opc_done)
        op_r <= sr_in;
      if (sck_rise & (bit_cnt_r > `SFP_OPC_LAST) & ~cmd_full)
        adr_r <= adr_in;
      if (adr_done)
        pos_r <= adr_in[`SFP_POS_MSB:`SFP_POS_LSB];
      else if (byte_done)
        pos_r <= pos_nxt;
      if (data_bit)
        dbit_r <= dbit_r + 3'h1;
    end
  end

  // ==========================================================
  // Opcode decode.
  logic       op_bwr;
  logic       op_pe;
  logic       op_pn;
  logic       op_mp;
  logic       op_rw;
  logic       op_xf;
  logic       op_cp;
  logic       op_sel;
  logic       op_array;
  logic [11:0] op_page;
  sfp_opk_e   op_kind;

  assign op_bwr = (op_r == `SFP_OP_BWR1) | (op_r == `SFP_OP_BWR2);
  assign op_pe  = (op_r == `SFP_OP_PE1) | (op_r == `SFP_OP_PE2);
  assign op_pn  = (op_r == `SFP_OP_PN1) | (op_r == `SFP_OP_PN2);
  assign op_mp  = (op_r == `SFP_OP_MP1) | (op_r == `SFP_OP_MP2);
  assign op_rw  = (op_r == `SFP_OP_RW1) | (op_r == `SFP_OP_RW2);
  assign op_xf  = (op_r == `SFP_OP_XF1) | (op_r == `SFP_OP_XF2);
  assign op_cp  = (op_r == `SFP_OP_CP1) | (op_r == `SFP_OP_CP2);
  assign op_sel = (op_r == `SFP_OP_BWR2) | (op_r == `SFP_OP_PE2)
                | (op_r == `SFP_OP_PN2) | (op_r == `SFP_OP_MP2)
                | (op_r == `SFP_OP_RW2) | (op_r == `SFP_OP_XF2)
                | (op_r == `SFP_OP_CP2);
  assign op_array = op_pe | op_pn | op_mp | op_rw | op_xf | op_cp;
  assign op_page  = adr_r[`SFP_PG_MSB:`SFP_PG_LSB];
  assign op_kind  = op_rw ? OPK_RW : (op_pn ? OPK_PN : (op_xf ? OPK_XFR
                  : (op_cp ? OPK_CMP : OPK_PE)));

  // ==========================================================
  // Host buffer write path.
  logic          host_we;
  logic [BW-1:0] host_bidx;

  assign host_we   = byte_done & (op_bwr | op_mp);
  assign host_bidx = op_sel ? BW'(pos_r) + BUF2_OFS : BW'(pos_r);

  // ==========================================================
  // Array engine.
  sfp_eng_e      eng_r;
  sfp_eng_e      eng_nxt;
  sfp_opk_e      kind_r;
  logic          esel_r;
  logic [PW-1:0] epg_r;
  logic [8:0]    eidx_r;
  logic          busy_r;
  logic          comp_r;
  logic          diff_r;
  logic          launch;
  logic          eidx_last;
  logic          tmr_zero;
  logic [TW-1:0] tmr_load;
  logic [AW-1:0] eaddr;
  logic [BW-1:0] ebidx;
  sfp_byte_t     pg_byte;
  sfp_byte_t     bf_byte;
  logic          byte_diff;

  // Array commands start only when complete and the array is free.
  assign launch    = cs_rise & cmd_full & op_array & ~busy_r;
  assign eidx_last = (eidx_r == POS_LAST);
  assign eaddr     = AW'(epg_r) * AW'(PAGE_BYTES) + AW'(eidx_r);
  assign ebidx     = esel_r ? BW'(eidx_r) + BUF2_OFS : BW'(eidx_r);
  assign pg_byte   = page_mem[eaddr];
  assign bf_byte   = buf_mem[ebidx];
  assign byte_diff = (pg_byte != bf_byte);
  assign tmr_load  = (op_kind == OPK_PN) ? LD_P
                   : (((op_kind == OPK_XFR) | (op_kind == OPK_CMP)) ? LD_XFR : LD_EP);

  always_comb
  begin
    eng_nxt = eng_r;
    unique case (eng_r)
      ENG_IDLE:
        if (launch)
          eng_nxt = ((op_kind == OPK_XFR) | (op_kind == OPK_RW)) ? ENG_FILL
                  : ((op_kind == OPK_CMP) ? ENG_CMP : ENG_PROG);
      ENG_FILL:
        if (eidx_last)
          eng_nxt = (kind_r == OPK_RW) ? ENG_PROG : ENG_WAIT;
      ENG_CMP:
        if (eidx_last)
          eng_nxt = ENG_WAIT;
      ENG_PROG:
        if (eidx_last)
          eng_nxt = ENG_WAIT;
      ENG_WAIT:
        if (tmr_zero)
          eng_nxt = ENG_IDLE;
      default:
        eng_nxt = ENG_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      eng_r  <= ENG_IDLE;
      kind_r <= OPK_PE;
      esel_r <= 1'b0;
      epg_r  <= '0;
      eidx_r <= 9'h000;
      busy_r <= 1'b0;
      comp_r <= 1'b0;
      diff_r <= 1'b0;
    end
    else
    begin
      eng_r  <= eng_nxt;
      busy_r <= (eng_nxt != ENG_IDLE);
      if (launch)
      begin
        kind_r <= op_kind;
        esel_r <= op_sel;
        epg_r  <= op_page[PW-1:0];
        eidx_r <= 9'h000;
        diff_r <= 1'b0;
      end
      else if ((eng_r == ENG_FILL) | (eng_r == ENG_CMP) | (eng_r == ENG_PROG))
        eidx_r <= eidx_last ? 9'h000 : eidx_r + 9'h001;
      if (eng_r == ENG_CMP)
      begin
        diff_r <= diff_r | byte_diff;
        if (eidx_last)
          comp_r <= diff_r | byte_diff;
      end
    end
  end

  // ==========================================================
  // Memory writes.
  always_ff @(posedge i_clk_sys)
  begin
    if (host_we)
      buf_mem[host_bidx] <= sr_in;
    if (eng_r == ENG_FILL)
      buf_mem[ebidx] <= pg_byte;
    if (eng_r == ENG_PROG)
    begin
      if (kind_r == OPK_PN)
        page_mem[eaddr] <= pg_byte & bf_byte;
      else
        page_mem[eaddr] <= bf_byte;
    end
  end

  sfp_timer #(
    .TW (TW)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_start   (launch),
    .i_load    (tmr_load),
    .o_zero    (tmr_zero)
  );

  // ==========================================================
  // Status read.
  sfp_byte_t  stat_live;
  logic       stat_on_r;
  logic       stat_adv_r;
  logic [2:0] stat_idx_r;
  logic       so_r;
  logic       so_oe_r;
  sfp_byte_t  status_r;

  assign stat_live = {~busy_r, comp_r, DENSITY, `SFP_RSV_BITS};

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      stat_on_r  <= 1'b0;
      stat_adv_r <= 1'b0;
      stat_idx_r <= `SFP_STAT_TOP;
    end
    else if (i_cs_n)
    begin
      stat_on_r  <= 1'b0;
      stat_adv_r <= 1'b0;
    end
    else if (opc_done)
    begin
      stat_on_r  <= (sr_in == `SFP_OP_STAT);
      stat_adv_r <= 1'b0;
      stat_idx_r <= `SFP_STAT_TOP;
    end
    else if (sck_fall & stat_on_r)
    begin
      stat_adv_r <= 1'b1;
      if (stat_adv_r)
        stat_idx_r <= stat_idx_r - 3'h1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      so_r     <= 1'b0;
      so_oe_r  <= 1'b0;
      status_r <= 8'h00;
    end
    else
    begin
      // The selected bit is resampled every cycle, so a parked clock shows live ready.
      so_r     <= stat_live[stat_idx_r];
      so_oe_r  <= stat_on_r & stat_adv_r & sel_on;
      status_r <= stat_live;
    end
  end

  assign o_so          = so_r;
  assign o_so_oe       = so_oe_r;
  assign o_rdy_busy    = 1'b0;
  assign o_rdy_busy_oe = busy_r;
  assign o_status      = status_r;
endmodule : sfp_core
`default_nettype wire

// >>> sfp_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module sfp_core_chk #(
  parameter int unsigned EP_CYC  = 900,
  parameter int unsigned XFR_CYC = 600,
  parameter logic [2:0]  DENSITY = 3'h5
) (
  input wire logic               i_clk_sys,
  input wire logic               i_rst,
  input wire logic               i_cs_n,
  input wire logic               o_so_oe,
  input wire logic               o_rdy_busy,
  input wire logic               o_rdy_busy_oe,
  input wire sfp_pkg::sfp_byte_t o_status
);
  import sfp_pkg::*;
  logic [31:0] busy_len_r;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      busy_len_r <= 32'h0;
    else
      busy_len_r <= o_rdy_busy_oe ? busy_len_r + 32'h1 : 32'h0;
  end
  chk_density_code: assert property (!$past(i_rst) |-> o_status[5:3] == DENSITY)
    else $error("density code wrong");
  chk_reserved_zero: assert property (!$past(i_rst) |-> o_status[2:0] == 3'h0)
    else $error("reserved status bits not zero");
  chk_pin_low: assert property (o_rdy_busy == 1'b0)
    else $error("ready pin level wrong");
  chk_busy_from_cs: assert property ($rose(o_rdy_busy_oe) |-> $past(i_cs_n) && !$past(i_cs_n, 2))
    else $error("busy began without select release");
  chk_busy_flag: assert property (o_rdy_busy_oe [*3] |-> !o_status[7])
    else $error("ready bit high while busy");
  chk_idle_ready: assert property (!o_rdy_busy_oe [*4] |-> o_status[7])
    else $error("ready bit low while idle");
  chk_busy_length: assert property ($fell(o_rdy_busy_oe) |->
    busy_len_r >= XFR_CYC - 2 && busy_len_r <= EP_CYC + 4)
    else $error("busy length out of range");
  chk_oe_after_cs: assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2) |-> !o_so_oe)
    else $error("output driven without select");
  chk_oe_in_frame: assert property ($rose(o_so_oe) |-> !i_cs_n && !$past(i_cs_n))
    else $error("output enabled outside a frame");
  chk_comp_in_busy: assert property ($changed(o_status[6]) |-> o_rdy_busy_oe)
    else $error("compare bit changed while idle");
endmodule : sfp_core_chk
bind sfp_core sfp_core_chk #(
  .EP_CYC (EP_CYC),
  .XFR_CYC(XFR_CYC)
) u_chk (
  .i_clk_sys    (i_clk_sys),
  .i_rst        (i_rst),
  .i_cs_n       (i_cs_n),
  .o_so_oe      (o_so_oe),
  .o_rdy_busy   (o_rdy_busy),
  .o_rdy_busy_oe(o_rdy_busy_oe),
  .o_status     (o_status)
);
`default_nettype wire

// >>> sfp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Serial host model
module sfp_host_model (
  input  wire logic i_clk_sys,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  task automatic tick(input int c);
    repeat (c) @(posedge i_clk_sys);
    #1;
  endtask : tick
  task automatic open_frame();
    o_cs_n = 1'b0;
    tick(3);
  endtask : open_frame
  task automatic close_frame();
    tick(3);
    o_cs_n = 1'b1;
    tick(1);
  endtask : close_frame
  task automatic shift_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      o_si = b[i];
      tick(3);
      r[i] = i_so;
      o_sck = 1'b1;
      tick(3);
      o_sck = 1'b0;
    end
  endtask : shift_byte
  task automatic send_cmd(input logic [7:0] op, input logic [11:0] pg, input logic [8:0] pos);
    logic [23:0] a;
    logic [7:0]  r;
    a = {3'h0, pg, pos};
    open_frame();
    shift_byte(op, r);
    for (int k = 0; k < 3; k++)
      shift_byte(a[23 - 8 * k -: 8], r);
  endtask : send_cmd
endmodule : sfp_host_model
`default_nettype wire

// >>> serial_flash_program_and_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module serial_flash_program_and_status_tb;
  import sfp_pkg::*;
  localparam int         EP  = 900;
  localparam int         PN  = 800;
  localparam int         XF  = 600;
  localparam logic [2:0] DEN = 3'h5;
  typedef struct {logic [7:0] op; int lim;} sfp_row_s;
  logic      i_clk_sys, i_rst, cs_n, sck, si, so, so_oe, rb, rb_oe, so_seen;
  sfp_byte_t status, s1, s2, r;
  int        num_errors, comparisons, n;
  sfp_row_s  rows [16];
  // A released serial output reads as the inverse of its last value.
  assign so_seen = so_oe ? so : ~so;
  sfp_host_model host (.i_clk_sys(i_clk_sys), .i_so(so_seen), .o_cs_n(cs_n), .o_sck(sck),
                       .o_si(si));
  sfp_core #(.EP_CYC(EP), .P_CYC(PN), .XFR_CYC(XF)) dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .o_rdy_busy(rb), .o_rdy_busy_oe(rb_oe), .o_status(status));
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic measure(input int lim);
    int i;
    n = 0;
    host.close_frame();
    for (i = 0; i < 1200 && !(n > 0 && rb_oe === 1'b0); i++)
    begin
      host.tick(1);
      n += int'(rb_oe === 1'b1);
    end
    check("busy end", rb_oe, 1'b0);
    if (rb_oe !== 1'b0)
      report_and_stop();
    check("busy cycles", lim == 0 ? n == 0 : n >= lim - 2 && n <= lim + 4, 1'b1);
    $display("busy %0d cycles, limit %0d", n, lim);
  endtask : measure
  task automatic run_op(input logic [7:0] op, input logic [11:0] pg, input int lim);
    host.send_cmd(op, pg, 9'h0);
    measure(lim);
  endtask : run_op
  task automatic cmp(input logic [7:0] op, input logic [11:0] pg, input logic exp);
    run_op(op, pg, XF);
    check("compare bit", status[6], exp);
  endtask : cmp
  task automatic fill(input logic [7:0] op, input logic [11:0] pg, input logic [8:0] pos,
                      input int cnt, input logic [7:0] seed);
    host.send_cmd(op, pg, pos);
    for (int k = 0; k < cnt; k++)
      host.shift_byte(seed ^ k[7:0], r);
  endtask : fill
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    i_rst = 1'b1;
    rows = '{'{8'h83, EP}, '{8'h86, EP}, '{8'h88, PN}, '{8'h89, PN}, '{8'h82, EP},
             '{8'h85, EP}, '{8'h58, EP}, '{8'h59, EP}, '{8'h53, XF}, '{8'h55, XF},
             '{8'h60, XF}, '{8'h61, XF}, '{8'h84, 0}, '{8'h87, 0}, '{8'h57, 0}, '{8'hFF, 0}};
    host.tick(5);
    i_rst = 1'b0;
    host.tick(2);
    check("reset status", status, {1'b1, 1'b0, DEN, 3'h0});
    foreach (rows[i])
      run_op(rows[i].op, 12'h9, rows[i].lim);
    fill(8'h84, 12'h0, 9'd260, 264, 8'h5A);
    measure(0);
    host.send_cmd(8'h83, 12'h3, 9'h0);
    host.close_frame();
    fill(8'h87, 12'h0, 9'h0, 2, 8'h11);
    host.close_frame();
    host.open_frame();
    host.shift_byte(8'h57, r);
    host.shift_byte(8'hFF, s1);
    host.shift_byte(8'hFF, s2);
    host.close_frame();
    check("busy status", {s1[7], s1[5:0]}, {1'b0, DEN, 3'h0});
    check("status repeat", s2, s1);
    host.open_frame();
    host.shift_byte(8'h57, r);
    host.tick(3);
    check("output busy", so_seen, 1'b0);
    for (n = 0; n < 1200 && so_seen !== 1'b1; n++)
      host.tick(1);
    check("output ready", so_seen, 1'b1);
    if (n == 1200)
      report_and_stop();
    host.close_frame();
    cmp(8'h60, 12'h3, 1'b0);
    fill(8'h84, 12'h0, 9'h5, 1, 8'hAC);
    measure(0);
    cmp(8'h60, 12'h3, 1'b1);
    run_op(8'h58, 12'h3, EP);
    cmp(8'h60, 12'h3, 1'b0);
    fill(8'h85, 12'h5, 9'h0, 264, 8'h33);
    measure(EP);
    cmp(8'h61, 12'h5, 1'b0);
    cmp(8'h60, 12'h5, 1'b1);
    host.send_cmd(8'h82, 12'h7, 9'h0);
    for (int k = 0; k < 264; k++)
      host.shift_byte(8'hFF, r);
    measure(EP);
    run_op(8'h89, 12'h7, PN);
    cmp(8'h61, 12'h7, 1'b0);
    host.open_frame();
    host.shift_byte(8'h83, r);
    host.shift_byte(8'h00, r);
    measure(0);
    $display("sequence tests done");
    host.send_cmd(8'h83, 12'h3, 9'h0);
    host.close_frame();
    host.tick(50);
    i_rst = 1'b1;
    host.tick(2);
    i_rst = 1'b0;
    host.tick(2);
    check("status after reset", status, {1'b1, 1'b0, DEN, 3'h0});
    check("busy after reset", rb_oe, 1'b0);
    $display("reset test done");
    report_and_stop();
  end
endmodule : serial_flash_program_and_status_tb
`default_nettype wire
